// file: hw/pin_protect_pkg.sv
package pin_protect_pkg;

   localparam int         INPUTS_W       = 5;
   localparam int         STRAP_W        = 4;
   localparam int         LOCK_W         = 35;
   localparam int         ADDR_W         = 8;
   localparam int         DATA_W         = 8;
   localparam int         BLK_W          = 6;
   localparam logic [5:0] BOOT_BLK       = 6'h22;
   localparam logic [7:0] OFS_INPUTS     = 8'h00;
   localparam logic [7:0] OFS_STRAP      = 8'h01;
   localparam logic [7:0] OFS_STATUS     = 8'h02;
   localparam logic [7:0] OFS_LOCK_SEL   = 8'h03;
   localparam logic [7:0] OFS_LOCK_DATA  = 8'h04;
   localparam logic [7:0] OFS_OP_CTRL    = 8'h05;
   localparam logic [7:0] OFS_LOAD_CNT   = 8'h06;
   localparam int         STAT_BUSY      = 0;
   localparam int         STAT_REFUSED   = 1;
   localparam int         STAT_ABORTED   = 2;
   localparam int         STAT_AUTO      = 3;
   localparam int         STAT_MATCH     = 4;
   localparam logic       LOCK_RESET     = 1'b1;
   localparam int         CLK_NS         = 10;
   localparam int         RST_LAT_NS     = 100;
   localparam int         RST_LAT_CYC    = (RST_LAT_NS + CLK_NS - 1) / CLK_NS;
   localparam int         OP_TIME_NS     = 7000;
   localparam int         OP_TIME_CYC    = OP_TIME_NS / CLK_NS;

   typedef struct packed {
      logic                top_lock_n;
      logic                protect_n;
      logic                auto_mode;
      logic                load_enable_n;
      logic [INPUTS_W-1:0] inputs;
      logic [STRAP_W-1:0]  strap;
   } pins_t;

   typedef struct packed {
      logic              start;
      logic [BLK_W-1:0]  block;
   } op_req_t;

endpackage

// file: hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W     = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Pin side
   input  wire logic [W-1:0] pin,
   // Filtered level
   output logic      [W-1:0] level
);
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [W-1:0] lvl_d;

   // Change counts only once the second and third stages agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s2_q[i];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= INIT;
         s2_q  <= INIT;
         s3_q  <= INIT;
         lvl_q <= INIT;
      end else begin
         s1_q  <= pin;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level = lvl_q;
endmodule
`default_nettype wire

// file: hw/lock_bits.sv
`timescale 1ns/1ps
`default_nettype none
module lock_bits (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   // Write port
   input  wire logic                                we,
   input  wire logic [pin_protect_pkg::BLK_W-1:0]   waddr,
   input  wire logic                                wdata,
   // Registered read port
   input  wire logic [pin_protect_pkg::BLK_W-1:0]   raddr,
   output logic                                     rdata,
   // Lookup port for the operation start
   input  wire logic [pin_protect_pkg::BLK_W-1:0]   laddr,
   output logic                                     ldata
);
   logic [pin_protect_pkg::LOCK_W-1:0] mem_q, mem_d;
   logic                               rd_q, rd_d;

   always_comb begin
      mem_d = mem_q;
      if (we && waddr < 6'(pin_protect_pkg::LOCK_W)) begin
         mem_d[waddr] = wdata;
      end
      rd_d = (raddr < 6'(pin_protect_pkg::LOCK_W)) ? mem_q[raddr] : 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_q <= {pin_protect_pkg::LOCK_W{pin_protect_pkg::LOCK_RESET}};
         rd_q  <= 1'b0;
      end else begin
         mem_q <= mem_d;
         rd_q  <= rd_d;
      end
   end

   assign rdata = rd_q;
   assign ldata = (laddr < 6'(pin_protect_pkg::LOCK_W)) ? mem_q[laddr] : 1'b1;
endmodule
`default_nettype wire

// file: hw/flash_pin_protect.sv
// Operation
// (R1) Five general input pin levels are captured into a readable register.
// (R2) Board holds general inputs stable across the whole register read.
// (R3) Auto-increment mode ignores general inputs two to four and top lock.
// (R4) Top lock low refuses program and erase of the top boot block.
// (R5) Top lock high leaves boot block protection to its lock bit only.
// (R6) Protect low blocks all other blocks; high removes that protection.
// (R7) Top and remaining protections are evaluated separately.
// (R8) Top lock input ORed with boot lock bit; register still reads back.
// (R9) Protect input ORed with each block lock bit; register still reads back.
// (R10) Host sets protection pins before an operation and holds them.
// (R11) Either reset input low starts a reset, both alike; here INIT_N only deselects and aborts, RESETN clears all.
// (R12) Reset during read deselects device and floats the data lines.
// (R13) Host holds reset low for at least the minimum pulse.
// (R14) Reset during an operation aborts it after a reset latency.
// (R15) System drives reset low during system reset.
// (R16) Board straps boot device select to zero, others count up.
// (R17) Supervoltage on protect pin selects auto-increment mode.
// (R18) Load enable low loads data, high ends the command.
// (R19) Ready/busy shows buffer free with load low, done with load high.
// (R20) Frame start begins a cycle; frame during a cycle abandons it.
// (R21) Respond only when received select equals the strapped select.
// (R22) Auto-increment with load low latches data on the rising edge.
// (R23) General input i sits at bit i; upper bits read zero.
// (R24) Protection decision is taken at operation start and held.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module flash_pin_protect (
   // Clock and resets
   input  wire logic                                 MCLK,
   input  wire logic                                 RESETN,
   input  wire logic                                 INIT_N,
   // Board pins
   input  wire logic [pin_protect_pkg::INPUTS_W-1:0] GENERAL_INPUTS,
   input  wire logic                                 TOP_BLOCK_LOCK_N,
   input  wire logic                                 PROTECT_N,
   input  wire logic                                 SUPERVOLTAGE_DET,
   input  wire logic                                 LOAD_ENABLE_N,
   input  wire logic [pin_protect_pkg::STRAP_W-1:0]  STRAP_SELECT,
   input  wire logic [7:0]                           AUTO_DATA,
   // Bus cycle framing from the cycle decoder
   input  wire logic                                 FRAME_START,
   input  wire logic [pin_protect_pkg::STRAP_W-1:0]  CYCLE_IDSEL,
   input  wire logic                                 CYCLE_DONE,
   input  wire logic                                 CYCLE_IS_READ,
   // Program and erase request from the command decoder
   input  wire logic                                 OP_START,
   input  wire logic [pin_protect_pkg::BLK_W-1:0]    OP_BLOCK,
   // Register port
   input  wire logic [pin_protect_pkg::ADDR_W-1:0]   REG_ADDR,
   input  wire logic [pin_protect_pkg::DATA_W-1:0]   REG_WDATA,
   input  wire logic                                 REG_WR,
   input  wire logic                                 REG_RD,
   output logic      [pin_protect_pkg::DATA_W-1:0]   REG_RDATA,
   // Status towards the array and bus
   output logic                                      CYCLE_ACTIVE,
   output logic                                      SELECTED,
   output logic                                      DATA_OE,
   output logic                                      OP_BUSY,
   output logic                                      OP_REFUSED,
   output logic                                      AUTO_MODE,
   output logic [7:0]                                AUTO_LATCHED,
   output logic                                      AUTO_STROBE,
   // Open-drain ready/busy
   output logic                                      READY_BUSY_N_OUT,
   output logic                                      READY_BUSY_N_OE
);
   typedef enum logic [1:0] {IDLE, RUN, ABORT} op_state_t;

   pin_protect_pkg::pins_t pins;
   logic [pin_protect_pkg::INPUTS_W-1:0] inputs_s;
   logic [4:0] ctl_s;

   pin_sync #(.W(pin_protect_pkg::INPUTS_W), .INIT('0)) u_inputs_sync (
      .clk   (MCLK),
      .rst_n (RESETN),
      .pin   (GENERAL_INPUTS),
      .level (inputs_s)
   );

   // Reset levels: protected, bus mode, load idle, second reset released, so no false reset follows
   pin_sync #(.W(5), .INIT(5'h03)) u_ctl_sync (
      .clk   (MCLK),
      .rst_n (RESETN),
      .pin   ({TOP_BLOCK_LOCK_N, PROTECT_N, SUPERVOLTAGE_DET, LOAD_ENABLE_N, INIT_N}),
      .level (ctl_s)
   );

   // (R11) INIT_N resets once filtered
   logic soft_rst;
   assign soft_rst = !ctl_s[0];

   always_comb begin
      pins.top_lock_n    = ctl_s[4];
      pins.protect_n     = ctl_s[3];
      pins.auto_mode     = ctl_s[2];
      pins.load_enable_n = ctl_s[1];
      pins.inputs        = inputs_s;
      pins.strap         = STRAP_SELECT;
   end

   // Straps caught after reset release
   logic [3:0] strap_q, strap_d;
   logic       strap_done_q, strap_done_d;
   always_comb begin
      strap_d      = strap_q;
      strap_done_d = 1'b1;
      if (!strap_done_q) begin
         strap_d = pins.strap;
      end
   end

   // Bus cycle tracking
   logic cyc_q, cyc_d, sel_q, sel_d, oe_q, oe_d;
   always_comb begin
      cyc_d = cyc_q;
      sel_d = sel_q;
      oe_d  = oe_q;
      // (R20) Frame restarts cycle
      if (FRAME_START) begin
         cyc_d = 1'b1;
         sel_d = 1'b0;
         oe_d  = 1'b0;
      end else if (cyc_q && CYCLE_DONE) begin
         cyc_d = 1'b0;
         sel_d = 1'b0;
         oe_d  = 1'b0;
      end else if (cyc_q) begin
         // (R21) Select match
         sel_d = (CYCLE_IDSEL == strap_q);
         oe_d  = sel_d && CYCLE_IS_READ;
      end
      // (R12) Reset deselects, floats data
      if (soft_rst) begin
         cyc_d = 1'b0;
         sel_d = 1'b0;
         oe_d  = 1'b0;
      end
   end

   // Lock bits and register access
   logic       lock_rd, lock_lk;
   logic [5:0] lock_sel_q, lock_sel_d;
   logic       lock_we;
   assign lock_we = REG_WR && (REG_ADDR == pin_protect_pkg::OFS_LOCK_DATA);

   lock_bits u_lock (
      .clk   (MCLK),
      .rst_n (RESETN),
      .we    (lock_we),
      .waddr (lock_sel_q),
      .wdata (REG_WDATA[0]),
      .raddr (lock_sel_d),
      .rdata (lock_rd),
      .laddr (OP_BLOCK),
      .ldata (lock_lk)
   );

   // Operation control
   op_state_t st_q, st_d;
   logic [9:0] cnt_q, cnt_d;
   logic       busy_q, busy_d, ref_q, ref_d, abt_q, abt_d;
   logic       top_prot, rest_prot, prot;
   always_comb begin
      // (R3) Top lock ignored in auto mode
      // (R4) (R5) (R8) Top block gating
      top_prot  = (!pins.top_lock_n && !pins.auto_mode) || lock_lk;
      // (R6) (R9) Remaining blocks gating
      rest_prot = (!pins.protect_n && !pins.auto_mode) || lock_lk;
      // (R7) Separate regions
      prot = (OP_BLOCK == pin_protect_pkg::BOOT_BLK) ? top_prot : rest_prot;
      st_d   = st_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      ref_d  = ref_q;
      abt_d  = abt_q;
      unique case (st_q)
         IDLE: begin
            // (R24) Decision taken once at start
            if (OP_START && !soft_rst) begin
               ref_d = prot;
               abt_d = 1'b0;
               if (!prot) begin
                  st_d   = RUN;
                  busy_d = 1'b1;
                  cnt_d  = 10'(pin_protect_pkg::OP_TIME_CYC - 1);
               end
            end
         end
         RUN: begin
            // (R14) Reset aborts after latency
            if (soft_rst) begin
               st_d  = ABORT;
               cnt_d = 10'(pin_protect_pkg::RST_LAT_CYC - 1);
            end else if (cnt_q == 10'h000) begin
               st_d   = IDLE;
               busy_d = 1'b0;
            end else begin
               cnt_d = cnt_q - 10'h001;
            end
         end
         ABORT: begin
            if (cnt_q == 10'h000) begin
               st_d   = IDLE;
               busy_d = 1'b0;
               abt_d  = 1'b1;
            end else begin
               cnt_d = cnt_q - 10'h001;
            end
         end
      endcase
   end

   // Auto-increment loading and ready/busy
   logic [7:0] alat_q, alat_d;
   logic [7:0] lcnt_q, lcnt_d;
   logic       astb_q, astb_d, rb_oe_q, rb_oe_d;
   always_comb begin
      alat_d = alat_q;
      lcnt_d = lcnt_q;
      astb_d = 1'b0;
      // (R17) (R18) (R22) Latch while load low
      if (pins.auto_mode && !pins.load_enable_n) begin
         alat_d = AUTO_DATA;
         lcnt_d = lcnt_q + 8'h01;
         astb_d = 1'b1;
      end
      // (R19) Load low: buffer free; high: programming done
      if (!pins.auto_mode) begin
         rb_oe_d = 1'b0;
      end else if (!pins.load_enable_n) begin
         rb_oe_d = 1'b0;
      end else begin
         rb_oe_d = busy_q;
      end
   end

   // Register file
   logic [7:0] rdata_q, rdata_d, status;
   always_comb begin
      lock_sel_d = lock_sel_q;
      if (REG_WR && REG_ADDR == pin_protect_pkg::OFS_LOCK_SEL) begin
         lock_sel_d = REG_WDATA[5:0];
      end
      status = 8'h00;
      status[pin_protect_pkg::STAT_BUSY]    = busy_q;
      status[pin_protect_pkg::STAT_REFUSED] = ref_q;
      status[pin_protect_pkg::STAT_ABORTED] = abt_q;
      status[pin_protect_pkg::STAT_AUTO]    = pins.auto_mode;
      status[pin_protect_pkg::STAT_MATCH]   = sel_q;
      rdata_d = 8'h00;
      if (REG_RD) begin
         unique case (REG_ADDR)
            // (R1) (R23) Input register, (R3) upper inputs masked in auto mode
            pin_protect_pkg::OFS_INPUTS:
               rdata_d = {3'h0, (pins.auto_mode ? 3'h0 : pins.inputs[4:2]), pins.inputs[1:0]};
            pin_protect_pkg::OFS_STRAP:    rdata_d = {4'h0, strap_q};
            pin_protect_pkg::OFS_STATUS:   rdata_d = status;
            pin_protect_pkg::OFS_LOCK_SEL: rdata_d = {2'h0, lock_sel_q};
            pin_protect_pkg::OFS_LOAD_CNT: rdata_d = lcnt_q;
            default:                       rdata_d = 8'h00;
         endcase
      end
   end

   // Lock data reads come from the registered lock read port
   logic rd_lock_q;

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         strap_q      <= 4'h0;
         strap_done_q <= 1'b0;
         cyc_q        <= 1'b0;
         sel_q        <= 1'b0;
         oe_q         <= 1'b0;
         st_q         <= IDLE;
         cnt_q        <= 10'h000;
         busy_q       <= 1'b0;
         ref_q        <= 1'b0;
         abt_q        <= 1'b0;
         alat_q       <= 8'h00;
         lcnt_q       <= 8'h00;
         astb_q       <= 1'b0;
         rb_oe_q      <= 1'b0;
         lock_sel_q   <= 6'h00;
         rdata_q      <= 8'h00;
         rd_lock_q    <= 1'b0;
      end else begin
         strap_q      <= strap_d;
         strap_done_q <= strap_done_d;
         cyc_q        <= cyc_d;
         sel_q        <= sel_d;
         oe_q         <= oe_d;
         st_q         <= st_d;
         cnt_q        <= cnt_d;
         busy_q       <= busy_d;
         ref_q        <= ref_d;
         abt_q        <= abt_d;
         alat_q       <= alat_d;
         lcnt_q       <= lcnt_d;
         astb_q       <= astb_d;
         rb_oe_q      <= rb_oe_d;
         lock_sel_q   <= lock_sel_d;
         rdata_q      <= rdata_d;
         rd_lock_q    <= REG_RD && (REG_ADDR == pin_protect_pkg::OFS_LOCK_DATA);
      end
   end

   assign REG_RDATA        = rd_lock_q ? {7'h00, lock_rd} : rdata_q;
   assign CYCLE_ACTIVE     = cyc_q;
   assign SELECTED         = sel_q;
   assign DATA_OE          = oe_q;
   assign OP_BUSY          = busy_q;
   assign OP_REFUSED       = ref_q;
   assign AUTO_MODE        = pins.auto_mode;
   assign AUTO_LATCHED     = alat_q;
   assign AUTO_STROBE      = astb_q;
   assign READY_BUSY_N_OUT = 1'b0;
   assign READY_BUSY_N_OE  = rb_oe_q;
endmodule
`default_nettype wire

// file: testbench/flash_pin_protect_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_pin_protect_checker (
   // Clock and resets
   input wire logic       MCLK,
   input wire logic       RESETN,
   input wire logic       INIT_N,
   // Pins
   input wire logic       TOP_BLOCK_LOCK_N,
   input wire logic       PROTECT_N,
   input wire logic       SUPERVOLTAGE_DET,
   // Requests
   input wire logic       OP_START,
   input wire logic [5:0] OP_BLOCK,
   input wire logic [7:0] REG_ADDR,
   input wire logic       REG_RD,
   // Outputs
   input wire logic [7:0] REG_RDATA,
   input wire logic       SELECTED,
   input wire logic       DATA_OE,
   input wire logic       OP_BUSY,
   input wire logic       OP_REFUSED,
   input wire logic       AUTO_MODE,
   input wire logic       AUTO_STROBE,
   input wire logic       READY_BUSY_N_OUT,
   input wire logic       READY_BUSY_N_OE
);
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);

   AST_INPUTS_UPPER_ZERO: assert property (
      REG_RD && REG_ADDR == pin_protect_pkg::OFS_INPUTS |=> REG_RDATA[7:5] == 3'h0)
      else $error("general input upper bits not zero");
   // Pin held for the synchroniser depth so the filtered level agrees
   AST_TOP_LOCK_REFUSES: assert property (
      OP_START && !OP_BUSY && OP_BLOCK == pin_protect_pkg::BOOT_BLK && !AUTO_MODE
      && !TOP_BLOCK_LOCK_N && $past(!TOP_BLOCK_LOCK_N, 5) |=> OP_REFUSED && !OP_BUSY)
      else $error("top block accepted while top lock low");
   AST_PROTECT_REFUSES: assert property (
      OP_START && !OP_BUSY && OP_BLOCK != pin_protect_pkg::BOOT_BLK && !AUTO_MODE
      && !PROTECT_N && $past(!PROTECT_N, 5) |=> OP_REFUSED && !OP_BUSY)
      else $error("block accepted while protect low");
   AST_BUSY_HOLDS: assert property (
      $rose(OP_BUSY) |-> OP_BUSY[*8])
      else $error("operation ended too early");
   AST_INIT_DESELECTS: assert property (
      (!INIT_N)[*7] |-> !SELECTED && !DATA_OE)
      else $error("still selected during second reset");
   AST_INIT_ABORTS: assert property (
      (!INIT_N)[*8] |-> ##[0:10] !OP_BUSY)
      else $error("operation not aborted by second reset");
   AST_AUTO_ENTER: assert property (
      SUPERVOLTAGE_DET[*6] |-> AUTO_MODE)
      else $error("auto mode not entered");
   AST_AUTO_LEAVE: assert property (
      (!SUPERVOLTAGE_DET)[*6] |-> !AUTO_MODE)
      else $error("auto mode not left");
   AST_STROBE_IN_AUTO: assert property (
      AUTO_STROBE |-> $past(AUTO_MODE))
      else $error("data latched outside auto mode");
   AST_READY_BUSY_OPEN_DRAIN: assert property (
      READY_BUSY_N_OE |-> READY_BUSY_N_OUT == 1'b0 && $past(OP_BUSY) && $past(AUTO_MODE))
      else $error("ready busy pulled low without an auto mode operation");

   cover property (OP_REFUSED);
   cover property ($fell(OP_BUSY));
   cover property (AUTO_STROBE);
endmodule
`default_nettype wire

// file: testbench/lpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model #(
   parameter int LEN = 40
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Bench request
   input  wire logic       go,
   input  wire logic [3:0] idsel_req,
   // Cycle signals towards the block
   output logic            frame_start,
   output logic [3:0]      cycle_idsel,
   output logic            cycle_done,
   output logic            cycle_is_read
);
   int         cnt_q;
   logic [3:0] id_q;
   // a new frame restarts the count, abandoning a cycle in progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 0;
         id_q  <= 4'h0;
      end else if (go) begin
         cnt_q <= LEN;
         id_q  <= idsel_req;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
   assign frame_start   = go;
   assign cycle_is_read = cnt_q > 0;
   assign cycle_done    = cnt_q == 1;
   // Outside a cycle the field is stale, so show its inverse rather than a held copy
   assign cycle_idsel   = go ? idsel_req : ((cnt_q > 0) ? id_q : ~id_q);
endmodule
`default_nettype wire

// file: testbench/flash_pin_protect_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_pin_protect_tb_top;
   localparam logic [5:0] BOOT = pin_protect_pkg::BOOT_BLK;
   logic       MCLK = 1'b0;
   logic       RESETN = 1'b0;
   logic       INIT_N = 1'b1;
   logic       TOP_BLOCK_LOCK_N = 1'b0;
   logic       PROTECT_N = 1'b0;
   logic       SUPERVOLTAGE_DET = 1'b0;
   logic       LOAD_ENABLE_N = 1'b1;
   logic       OP_START = 1'b0;
   logic       REG_WR = 1'b0;
   logic       REG_RD = 1'b0;
   logic       go = 1'b0;
   logic [4:0] GENERAL_INPUTS = 5'h15;
   logic [3:0] STRAP_SELECT = 4'h3;
   logic [3:0] go_idsel = 4'h0;
   logic [5:0] OP_BLOCK = 6'h00;
   logic [7:0] AUTO_DATA = 8'h00;
   logic [7:0] REG_ADDR = 8'h00;
   logic [7:0] REG_WDATA = 8'h00;
   logic [7:0] REG_RDATA, AUTO_LATCHED;
   logic [3:0] CYCLE_IDSEL;
   logic       FRAME_START, CYCLE_DONE, CYCLE_IS_READ, CYCLE_ACTIVE, SELECTED, DATA_OE;
   logic       OP_BUSY, OP_REFUSED, AUTO_MODE, AUTO_STROBE, READY_BUSY_N_OUT, READY_BUSY_N_OE;
   int         num_errors = 0;
   int         check_count = 0;
   int         cycles = 0;
   int         n;

   always #5 MCLK = ~MCLK;

   flash_pin_protect flash_pin_protect_inst (.MCLK, .RESETN, .INIT_N, .GENERAL_INPUTS, .TOP_BLOCK_LOCK_N, .PROTECT_N,
      .SUPERVOLTAGE_DET, .LOAD_ENABLE_N, .STRAP_SELECT, .AUTO_DATA, .FRAME_START, .CYCLE_IDSEL, .CYCLE_DONE,
      .CYCLE_IS_READ, .OP_START, .OP_BLOCK, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .CYCLE_ACTIVE,
      .SELECTED, .DATA_OE, .OP_BUSY, .OP_REFUSED, .AUTO_MODE, .AUTO_LATCHED, .AUTO_STROBE, .READY_BUSY_N_OUT,
      .READY_BUSY_N_OE);
   lpc_host_model lpc_host_model_inst (.clk(MCLK), .rst_n(RESETN), .go, .idsel_req(go_idsel),
      .frame_start(FRAME_START), .cycle_idsel(CYCLE_IDSEL), .cycle_done(CYCLE_DONE), .cycle_is_read(CYCLE_IS_READ));

   task automatic close_out();
      if (num_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge MCLK);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge MCLK);
      REG_WR <= 1'b0;
      @(posedge MCLK);
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      @(negedge MCLK);
      check(what, REG_RDATA, exp);
      @(posedge MCLK);
   endtask
   task automatic lock(input logic [5:0] blk, input logic v);
      reg_wr(pin_protect_pkg::OFS_LOCK_SEL, {2'h0, blk});
      reg_wr(pin_protect_pkg::OFS_LOCK_DATA, {7'h00, v});
      reg_rd(pin_protect_pkg::OFS_LOCK_DATA, {7'h00, v}, "lock bit");
   endtask
   task automatic op_start(input logic [5:0] blk, input logic ok);
      OP_BLOCK <= blk;
      OP_START <= 1'b1;
      @(posedge MCLK);
      OP_START <= 1'b0;
      @(negedge MCLK);
      check("busy", OP_BUSY, ok);
      check("refused", OP_REFUSED, !ok);
      @(posedge MCLK);
   endtask
   task automatic op_wait(input logic ok);
      for (n = 0; n < 800 && OP_BUSY !== 1'b0; n++) @(posedge MCLK);
      check("busy end", OP_BUSY, 1'b0);
      if (ok) check("op time", n > 670 && n < 710, 1'b1);
   endtask
   task automatic op(input logic [5:0] blk, input logic ok);
      op_start(blk, ok);
      op_wait(ok);
   endtask
   task automatic cycle(input logic [3:0] id);
      go_idsel <= id;
      go <= 1'b1;
      @(posedge MCLK);
      go <= 1'b0;
      for (n = 0; n < 10 && SELECTED !== 1'b1; n++) @(posedge MCLK);
   endtask

   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors = num_errors + 1;
         close_out();
      end
   end

   initial begin
      // reset held low over several cycles
      tick(4);
      RESETN <= 1'b1;
      tick(6);
      reg_rd(pin_protect_pkg::OFS_INPUTS, 8'h15, "inputs");
      GENERAL_INPUTS <= 5'h0a;
      tick(6);
      reg_rd(pin_protect_pkg::OFS_INPUTS, 8'h0a, "inputs");
      reg_rd(pin_protect_pkg::OFS_STRAP, 8'h03, "strap");
      reg_rd(8'h7f, 8'h00, "unmapped");
      reg_wr(pin_protect_pkg::OFS_LOCK_SEL, {2'h0, BOOT});
      reg_rd(pin_protect_pkg::OFS_LOCK_DATA, 8'h01, "boot lock reset");
      lock(BOOT, 1'b0);
      op(BOOT, 1'b0);
      // protection pins set before the operation
      TOP_BLOCK_LOCK_N <= 1'b1;
      tick(6);
      op(BOOT, 1'b1);
      lock(BOOT, 1'b1);
      op(BOOT, 1'b0);
      lock(6'h00, 1'b0);
      op(6'h00, 1'b0);
      TOP_BLOCK_LOCK_N <= 1'b0;
      PROTECT_N <= 1'b1;
      tick(6);
      op(6'h00, 1'b1);
      op(6'h01, 1'b0);
      // host loads with load enable low, ends with it high
      SUPERVOLTAGE_DET <= 1'b1;
      LOAD_ENABLE_N <= 1'b0;
      AUTO_DATA <= 8'h5a;
      tick(8);
      check("auto mode", AUTO_MODE, 1'b1);
      check("latched", AUTO_LATCHED, 8'h5a);
      check("buffer free", READY_BUSY_N_OE, 1'b0);
      reg_rd(pin_protect_pkg::OFS_INPUTS, 8'h02, "auto inputs");
      LOAD_ENABLE_N <= 1'b1;
      lock(BOOT, 1'b0);
      op_start(BOOT, 1'b1);
      tick(10);
      check("programming", READY_BUSY_N_OE, 1'b1);
      op_wait(1'b1);
      SUPERVOLTAGE_DET <= 1'b0;
      tick(6);
      check("auto mode", AUTO_MODE, 1'b0);
      cycle(4'h5);
      check("selected", SELECTED, 1'b0);
      cycle(4'h3);
      check("selected", SELECTED, 1'b1);
      check("cycle active", CYCLE_ACTIVE, 1'b1);
      check("read drive", DATA_OE, 1'b1);
      cycle(4'h5);
      tick(8);
      check("abandoned", SELECTED, 1'b0);
      cycle(4'h3);
      op_start(6'h00, 1'b1);
      INIT_N <= 1'b0;
      tick(20);
      check("init deselect", SELECTED, 1'b0);
      check("init float", DATA_OE, 1'b0);
      check("init abort", OP_BUSY, 1'b0);
      INIT_N <= 1'b1;
      tick(6);
      reg_rd(pin_protect_pkg::OFS_STATUS, 8'h04, "aborted status");
      close_out();
   end
endmodule

bind flash_pin_protect flash_pin_protect_checker flash_pin_protect_checker_inst (.MCLK, .RESETN, .INIT_N,
   .TOP_BLOCK_LOCK_N, .PROTECT_N, .SUPERVOLTAGE_DET, .OP_START, .OP_BLOCK, .REG_ADDR, .REG_RD, .REG_RDATA,
   .SELECTED, .DATA_OE, .OP_BUSY, .OP_REFUSED, .AUTO_MODE, .AUTO_STROBE, .READY_BUSY_N_OUT, .READY_BUSY_N_OE);
`default_nettype wire
